// File: rtl/srq_status_top.sv
// Purpose: status byte, standard event group, service request and error queue
// Assumes: strobes and event inputs are one-cycle pulses synchronous to clk_in
// Notes:   query answers appear one edge after the strobe and stand until the next
//
// Operation
// - standard event latch is read-only; every read returns it then clears it, except bits set by an event in the same cycle
// - bit 0 set when all commands through operation-complete have run
// - bit 2 set on query faults: empty read, interrupted query, buffers full
// - bit 3 set on device-specific faults including self-test and calibration
// - bit 4 set when a command fails during execution
// - bit 5 set when a received command has a syntax error
// - bit 7 set after power-up, held until read or cleared
// - event enable mask is read/write and gates latched bits into summary
// - status bit 2 high while error queue holds entries; queries or clear status remove them
// - status bit 3 is OR of enabled questionable event bits
// - status bit 4 high while the output queue holds unread messages
// - status bit 5 is OR of enabled standard event bits
// - status bit 7 is OR of enabled operation event bits
// - master summary is unlatched OR of status bits under service enable mask
// - status query returns master summary in bit 6, disturbs nothing
// - a service request drives the request line and latches bit 6
// - serial poll returns latched request bit 6, clears it, leaves others
// - error queue is first-in first-out; overflow rewrites newest entry
// - a set event bit ignores further occurrences of the same event
// - masks and reads are binary weighted, bit n weighs two to the n
`default_nettype none
`include "srq_defines.svh"
module srq_status_top #(
    parameter int GRP_W      = 16,
    parameter int ERRQ_DEPTH = `SRQ_ERRQ_DEPTH
) (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  sys_rst_in,
    // standard event sources
    input  wire logic                  opc_done_in,
    input  wire logic                  query_err_in,
    input  wire logic                  device_err_in,
    input  wire logic                  exec_err_in,
    input  wire logic                  cmd_err_in,
    // standard event register access
    input  wire logic                  sev_rd_in,
    input  wire logic                  clear_status_in,
    output logic [7:0]                 sev_data_out,
    input  wire logic                  ese_wr_in,
    input  wire logic [7:0]            ese_data_in,
    output logic [7:0]                 ese_out,
    // group summaries from outside
    input  wire logic [GRP_W-1:0]      ques_event_in,
    input  wire logic [GRP_W-1:0]      ques_enable_in,
    input  wire logic [GRP_W-1:0]      oper_event_in,
    input  wire logic [GRP_W-1:0]      oper_enable_in,
    input  wire logic                  out_queue_busy_in,
    // status byte and service request
    input  wire logic                  sre_wr_in,
    input  wire logic [7:0]            sre_data_in,
    output logic [7:0]                 sre_out,
    input  wire logic                  stb_rd_in,
    output logic [7:0]                 stb_out,
    input  wire logic                  spoll_in,
    output logic [7:0]                 spoll_out,
    output logic                       srq_out,
    // error queue
    input  wire logic                  err_push_in,
    input  wire logic [15:0]           err_code_in,
    input  wire logic                  err_rd_in,
    output logic [15:0]                err_code_out
);
    srq_sev_if  sev ();
    srq_errq_if eq ();

    srq_std_event u_sev (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .sev        (sev.leaf)
    );

    srq_err_queue #(
        .DEPTH (ERRQ_DEPTH)
    ) u_errq (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .eq         (eq.leaf)
    );

    // status byte assembly
    srq_pkg::srq_byte_type sb;
    logic                  master_summary;
    logic                  mss_rise;

    // registered state
    srq_pkg::srq_byte_type sev_data_r;
    srq_pkg::srq_byte_type sev_data_nxt;
    srq_pkg::srq_byte_type sre_r;
    srq_pkg::srq_byte_type sre_nxt;
    srq_pkg::srq_byte_type stb_r;
    srq_pkg::srq_byte_type stb_nxt;
    srq_pkg::srq_byte_type spoll_r;
    srq_pkg::srq_byte_type spoll_nxt;
    logic                  rqs_r;
    logic                  rqs_nxt;
    logic                  mss_prev_r;
    srq_pkg::srq_err_type  err_r;
    srq_pkg::srq_err_type  err_nxt;

    // event vector, one bit per weighted position
    always_comb begin
        sev.ev                  = 8'h00;
        sev.ev[`SRQ_SEV_OPC]    = opc_done_in;
        sev.ev[`SRQ_SEV_QUERY]  = query_err_in;
        sev.ev[`SRQ_SEV_DEVICE] = device_err_in;
        sev.ev[`SRQ_SEV_EXEC]   = exec_err_in;
        sev.ev[`SRQ_SEV_CMD]    = cmd_err_in;
    end

    assign sev.rd        = sev_rd_in;
    assign sev.cls       = clear_status_in;
    assign sev.ese_wr    = ese_wr_in;
    assign sev.ese_wdata = ese_data_in;

    assign eq.push      = err_push_in;
    assign eq.push_code = err_code_in;
    assign eq.pop       = err_rd_in;
    assign eq.clr       = clear_status_in;

    always_comb begin
        sb                = 8'h00;
        sb[`SRQ_STB_ERRQ] = eq.not_empty;
        sb[`SRQ_STB_QUES] = |(ques_event_in & ques_enable_in);
        sb[`SRQ_STB_MAV]  = out_queue_busy_in;
        sb[`SRQ_STB_ESB]  = sev.summary;
        sb[`SRQ_STB_OPER] = |(oper_event_in & oper_enable_in);
    end

    // real-time summary, never latched
    assign master_summary      = |(sb & sre_r & `SRQ_SRE_USED);
    assign mss_rise = master_summary && !mss_prev_r;

    always_comb begin
        sev_data_nxt = sev_rd_in ? sev.latch : sev_data_r;
        sre_nxt      = sre_wr_in ? (sre_data_in & `SRQ_SRE_USED) : sre_r;
        stb_nxt      = stb_r;
        if (stb_rd_in) begin
            stb_nxt                = sb;
            stb_nxt[`SRQ_STB_MSS]  = master_summary;
        end
        spoll_nxt = spoll_r;
        if (spoll_in) begin
            spoll_nxt               = sb;
            spoll_nxt[`SRQ_STB_MSS] = rqs_r;
        end
        // a new rise wins over the poll that clears
        rqs_nxt = mss_rise || (rqs_r && !spoll_in);
        err_nxt = err_rd_in ? eq.head : err_r;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sev_data_r <= 8'h00;
            sre_r      <= `SRQ_SRE_RESET;
            stb_r      <= 8'h00;
            spoll_r    <= 8'h00;
            rqs_r      <= 1'b0;
            mss_prev_r <= 1'b0;
            err_r      <= `SRQ_ERR_NONE;
        end else begin
            sev_data_r <= sev_data_nxt;
            sre_r      <= sre_nxt;
            stb_r      <= stb_nxt;
            spoll_r    <= spoll_nxt;
            rqs_r      <= rqs_nxt;
            mss_prev_r <= master_summary;
            err_r      <= err_nxt;
        end
    end

    assign sev_data_out = sev_data_r;
    assign ese_out      = sev.ese;
    assign sre_out      = sre_r;
    assign stb_out      = stb_r;
    assign spoll_out    = spoll_r;
    assign srq_out      = rqs_r;
    assign err_code_out = err_r;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    stb_mss_bit_a: assert property (stb_rd_in |=> stb_out[`SRQ_STB_MSS] == $past(master_summary))
        else $error("query lost master summary");

    stb_nodisturb_a: assert property (stb_rd_in && !spoll_in && !mss_rise && rqs_r
        |=> srq_out)
        else $error("status query disturbed request bit");

    stb_groups_a: assert property (stb_rd_in |=>
        stb_out[`SRQ_STB_QUES] == $past(|(ques_event_in & ques_enable_in)) &&
        stb_out[`SRQ_STB_OPER] == $past(|(oper_event_in & oper_enable_in)))
        else $error("group summary wrong");

    stb_queues_a: assert property (stb_rd_in |=>
        stb_out[`SRQ_STB_MAV] == $past(out_queue_busy_in) &&
        stb_out[`SRQ_STB_ERRQ] == $past(eq.not_empty))
        else $error("queue bit wrong");

    stb_esb_a: assert property (stb_rd_in |=>
        stb_out[`SRQ_STB_ESB] == $past(|(sev.latch & sev.ese)))
        else $error("event summary wrong");

    reserved_zero_a: assert property (stb_out[1:0] == 2'b00 && spoll_out[1:0] == 2'b00)
        else $error("unused status bit set");

    rise_request_a: assert property (master_summary && !mss_prev_r |=> srq_out ##1 (srq_out || $past(spoll_in)))
        else $error("rise did not request service");

    no_rerequest_a: assert property (!mss_rise && !rqs_r |=> !srq_out)
        else $error("request raised without rise");

    poll_clears_a: assert property (spoll_in && !mss_rise |=> !srq_out &&
        spoll_out[`SRQ_STB_MSS] == $past(rqs_r) &&
        spoll_out[5:0] == $past(sb[5:0]))
        else $error("serial poll answer wrong");

    mss_live_a: assert property (sre_wr_in && sre_data_in == 8'h04 ##1
        (eq.not_empty && !sre_wr_in) |-> master_summary)
        else $error("summary not combinational");

    err_read_a: assert property (err_rd_in |=> err_code_out == $past(eq.head))
        else $error("error read wrong");

    poll_cov_a: cover property (srq_out ##1 spoll_in ##1 !srq_out);
    stb_cov_a:  cover property (stb_rd_in && master_summary);
    err_cov_a:  cover property (eq.not_empty ##1 err_rd_in ##1 !eq.not_empty);
endmodule
`default_nettype wire

// File: rtl/srq_defines.svh
// Purpose: constants of the status reporting block
// Assumes: bit n of every byte carries the weight 2**n
// Notes:   definitions only
`ifndef SRQ_DEFINES_SVH
`define SRQ_DEFINES_SVH

// standard event bit positions
`define SRQ_SEV_OPC       0
`define SRQ_SEV_QUERY     2
`define SRQ_SEV_DEVICE    3
`define SRQ_SEV_EXEC      4
`define SRQ_SEV_CMD       5
`define SRQ_SEV_PON       7
`define SRQ_SEV_USED      8'hbd
`define SRQ_SEV_RESET     8'h80
`define SRQ_ESE_RESET     8'h00

// status byte bit positions
`define SRQ_STB_ERRQ      2
`define SRQ_STB_QUES      3
`define SRQ_STB_MAV       4
`define SRQ_STB_ESB       5
`define SRQ_STB_MSS       6
`define SRQ_STB_OPER      7
`define SRQ_SRE_RESET     8'h00
`define SRQ_SRE_USED      8'hbc

// error queue
`define SRQ_ERRQ_DEPTH    8
`define SRQ_ERR_OVERFLOW  16'hfea2
`define SRQ_ERR_NONE      16'h0000

`endif

// File: rtl/srq_pkg.sv
// Purpose: shared types of the status reporting block
// Assumes: nothing
// Notes:   constants live in srq_defines.svh
`default_nettype none
package srq_pkg;
    typedef logic [7:0]         srq_byte_type;
    typedef logic signed [15:0] srq_err_type;
endpackage
`default_nettype wire

// File: rtl/srq_link_if.sv
// Purpose: carriers between the top and its two leaf modules
// Assumes: one clock
// Notes:   ctl is the top side, leaf is the worker side
`default_nettype none
interface srq_sev_if;
    srq_pkg::srq_byte_type ev;
    logic                  rd;
    logic                  cls;
    logic                  ese_wr;
    srq_pkg::srq_byte_type ese_wdata;
    srq_pkg::srq_byte_type latch;
    srq_pkg::srq_byte_type ese;
    logic                  summary;
    modport ctl  (output ev, rd, cls, ese_wr, ese_wdata, input latch, ese, summary);
    modport leaf (input ev, rd, cls, ese_wr, ese_wdata, output latch, ese, summary);
endinterface

interface srq_errq_if;
    logic                 push;
    srq_pkg::srq_err_type push_code;
    logic                 pop;
    logic                 clr;
    srq_pkg::srq_err_type head;
    logic                 not_empty;
    modport ctl  (output push, push_code, pop, clr, input head, not_empty);
    modport leaf (input push, push_code, pop, clr, output head, not_empty);
endinterface
`default_nettype wire

// File: rtl/srq_std_event.sv
// Purpose: standard event latch, its enable mask and group summary
// Assumes: event pulses are one cycle wide
// Notes:   read and clear return the latch to zero, except bits set by an event in the same cycle
`default_nettype none
`include "srq_defines.svh"
module srq_std_event (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // carrier
    srq_sev_if.leaf   sev
);
    srq_pkg::srq_byte_type latch_r;
    srq_pkg::srq_byte_type latch_nxt;
    srq_pkg::srq_byte_type ese_r;
    srq_pkg::srq_byte_type ese_nxt;

    always_comb begin
        // set wins over the clearing read
        latch_nxt = ((sev.rd || sev.cls) ? 8'h00 : latch_r)
                    | (sev.ev & `SRQ_SEV_USED);
        ese_nxt = sev.ese_wr ? sev.ese_wdata : ese_r;
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            latch_r <= `SRQ_SEV_RESET;
            ese_r   <= `SRQ_ESE_RESET;
        end else begin
            latch_r <= latch_nxt;
            ese_r   <= ese_nxt;
        end
    end

    assign sev.latch   = latch_r;
    assign sev.ese     = ese_r;
    assign sev.summary = |(latch_r & ese_r);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    read_clears_a: assert property (sev.rd && sev.ev == 8'h00 |=> latch_r == 8'h00)
        else $error("latch not cleared by read");
    event_sets_a: assert property (##1 ((latch_r & $past(sev.ev & `SRQ_SEV_USED))
        == $past(sev.ev & `SRQ_SEV_USED)))
        else $error("event not latched");
    unused_zero_a: assert property (latch_r[1] == 1'b0 && latch_r[6] == 1'b0)
        else $error("unused event bit set");
    pon_hold_a: assert property (latch_r[`SRQ_SEV_PON] && !sev.rd && !sev.cls
        |=> latch_r[`SRQ_SEV_PON])
        else $error("power bit lost");
    ese_write_a: assert property (sev.ese_wr |=> ese_r == $past(sev.ese_wdata))
        else $error("mask write lost");
    pon_cov_a: cover property (latch_r[`SRQ_SEV_PON] ##1 sev.rd ##1 latch_r == 8'h00);
endmodule
`default_nettype wire

// File: rtl/srq_err_queue.sv
// Purpose: first-in first-out error queue
// Assumes: push and pop may come in the same cycle
// Notes:   a push into a full queue rewrites the newest entry
`default_nettype none
`include "srq_defines.svh"
module srq_err_queue #(
    parameter int DEPTH = `SRQ_ERRQ_DEPTH
) (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    // carrier
    srq_errq_if.leaf  eq
);
    localparam int AW = $clog2(DEPTH);

    srq_pkg::srq_err_type mem_r   [DEPTH];
    srq_pkg::srq_err_type mem_nxt [DEPTH];
    logic [AW-1:0]        rd_r;
    logic [AW-1:0]        rd_nxt;
    logic [AW-1:0]        wr_r;
    logic [AW-1:0]        wr_nxt;
    logic [AW:0]          cnt_r;
    logic [AW:0]          cnt_nxt;
    logic                 full;
    logic                 do_pop;
    logic [AW-1:0]        last;

    assign full   = (cnt_r == (AW+1)'(DEPTH));
    assign do_pop = eq.pop && (cnt_r != '0);
    assign last   = (wr_r == '0) ? AW'(DEPTH - 1) : wr_r - 1'b1;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        step = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_ent
            always_comb begin
                mem_nxt[i] = mem_r[i];
                if (eq.push && full && !do_pop && last == AW'(i)) begin
                    mem_nxt[i] = `SRQ_ERR_OVERFLOW;
                end else if (eq.push && (!full || do_pop) && wr_r == AW'(i)) begin
                    mem_nxt[i] = eq.push_code;
                end
            end
            always_ff @(posedge clk_in) begin
                mem_r[i] <= mem_nxt[i];
            end
        end
    endgenerate

    always_comb begin
        rd_nxt  = do_pop ? step(rd_r) : rd_r;
        wr_nxt  = (eq.push && (!full || do_pop)) ? step(wr_r) : wr_r;
        cnt_nxt = cnt_r;
        if (eq.push && !full && !do_pop) begin
            cnt_nxt = cnt_r + 1'b1;
        end else if (do_pop && !eq.push) begin
            cnt_nxt = cnt_r - 1'b1;
        end
        if (eq.clr) begin
            rd_nxt  = '0;
            wr_nxt  = '0;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_r  <= '0;
            wr_r  <= '0;
            cnt_r <= '0;
        end else begin
            rd_r  <= rd_nxt;
            wr_r  <= wr_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign eq.head      = (cnt_r == '0) ? `SRQ_ERR_NONE : mem_r[rd_r];
    assign eq.not_empty = (cnt_r != '0);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    overflow_mark_a: assert property (eq.push && full && !eq.pop && !eq.clr
        |=> mem_r[$past(last)] == `SRQ_ERR_OVERFLOW && full)
        else $error("overflow code not stored");
    fifo_order_a: assert property (!eq.not_empty && eq.push && !eq.clr
        |=> eq.head == $past(eq.push_code))
        else $error("first entry not at head");
    overflow_cov_a: cover property (full && eq.push && !eq.pop);
endmodule
`default_nettype wire

// File: tb/srq_ctrl_model.sv
// Purpose: bus controller that serial-polls the device on a service request
// Assumes: poll strobe is one cycle wide, answer stands one cycle later
// Notes:   delay_in sets how slowly a request is answered
`default_nettype none
module srq_ctrl_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // control from bench
    input  wire logic       en_in,
    input  wire logic [3:0] delay_in,
    // device side
    input  wire logic       srq_in,
    input  wire logic [7:0] spoll_data_in,
    output logic            spoll_out,
    output logic [7:0]      poll_byte_out,
    output logic [7:0]      poll_cnt_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        spoll_out     = 1'b0;
        poll_byte_out = 8'h00;
        poll_cnt_out  = 8'h00;
    end
    // one poll per request, answer taken once it has landed
    always begin
        @(posedge clk_in);
        if (!sys_rst_in && en_in && srq_in) begin
            repeat (delay_in) @(posedge clk_in);
            spoll_out <= 1'b1;
            @(posedge clk_in);
            spoll_out <= 1'b0;
            @(posedge clk_in);
            poll_byte_out <= spoll_data_in;
            poll_cnt_out  <= poll_cnt_out + 8'h01;
        end
    end
endmodule
`default_nettype wire

// File: tb/srq_status_top_tb.sv
// Purpose: self-checking bench of the status reporting block
// Assumes: design defaults for group width and queue depth
// Notes:   expected values come from bench functions
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module srq_status_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 8;
    logic        clk_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [4:0]  ev_v = 5'h00;
    logic [6:0]  st_v = 7'h00;
    logic [7:0]  ese_d = 8'h00;
    logic [7:0]  sre_d = 8'h00;
    logic [15:0] ques_ev = 16'h0000;
    logic [15:0] ques_en = 16'h0000;
    logic [15:0] oper_ev = 16'h0000;
    logic [15:0] oper_en = 16'h0000;
    logic        busy = 1'b0;
    logic [15:0] err_code = 16'h0000;
    logic        model_en = 1'b0;
    logic [3:0]  model_dly = 4'h0;
    logic [7:0]  sev_q, ese_q, sre_q, stb_q, spoll_q, poll_byte, poll_cnt, cnt0;
    logic [15:0] err_q;
    logic        srq, spoll_s;
    logic [7:0]  exp_sev = 8'h80;
    logic [7:0]  exp_ese = 8'h00;
    logic [7:0]  exp_sre = 8'h00;
    logic [15:0] q[$];
    logic [31:0] r;
    int          bad_count = 0;
    int          n_compared = 0;
    int          seed;

    always #20 clk_in = ~clk_in;

    srq_status_top #(.ERRQ_DEPTH(DEPTH)) u_srq_status_top (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .opc_done_in(ev_v[0]), .query_err_in(ev_v[1]), .device_err_in(ev_v[2]),
        .exec_err_in(ev_v[3]), .cmd_err_in(ev_v[4]),
        .sev_rd_in(st_v[0]), .clear_status_in(st_v[1]), .sev_data_out(sev_q),
        .ese_wr_in(st_v[2]), .ese_data_in(ese_d), .ese_out(ese_q),
        .ques_event_in(ques_ev), .ques_enable_in(ques_en),
        .oper_event_in(oper_ev), .oper_enable_in(oper_en), .out_queue_busy_in(busy),
        .sre_wr_in(st_v[3]), .sre_data_in(sre_d), .sre_out(sre_q),
        .stb_rd_in(st_v[4]), .stb_out(stb_q), .spoll_in(spoll_s), .spoll_out(spoll_q),
        .srq_out(srq), .err_push_in(st_v[6]), .err_code_in(err_code),
        .err_rd_in(st_v[5]), .err_code_out(err_q));

    srq_ctrl_model u_srq_ctrl_model (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .en_in(model_en),
        .delay_in(model_dly), .srq_in(srq), .spoll_data_in(spoll_q),
        .spoll_out(spoll_s), .poll_byte_out(poll_byte), .poll_cnt_out(poll_cnt));

    function automatic logic [7:0] stb_f();
        logic [7:0] s;
        s    = 8'h00;
        s[2] = q.size() != 0;
        s[3] = |(ques_ev & ques_en);
        s[4] = busy;
        s[5] = |(exp_sev & exp_ese);
        s[7] = |(oper_ev & oper_en);
        s[6] = |(s & exp_sre);
        return s;
    endfunction

    task automatic pulse(input int i);
        @(posedge clk_in);
        st_v[i] <= 1'b1;
        @(posedge clk_in);
        st_v[i] <= 1'b0;
        #1;
    endtask

    task automatic event_pulse(input logic [4:0] v);
        @(posedge clk_in);
        ev_v <= v;
        @(posedge clk_in);
        ev_v <= 5'h00;
        exp_sev = exp_sev | {2'b00, v[4:1], 1'b0, v[0]};
    endtask

    task automatic read_sev();
        pulse(0);
        `CHK("sev", exp_sev, sev_q)
        exp_sev = 8'h00;
    endtask

    task automatic check_stb();
        pulse(4);
        `CHK("stb", stb_f(), stb_q)
    endtask

    task automatic wr_masks(input logic [7:0] e, input logic [7:0] m);
        @(posedge clk_in);
        ese_d <= e;
        sre_d <= m;
        st_v[3:2] <= 2'b11;
        @(posedge clk_in);
        st_v[3:2] <= 2'b00;
        #1;
        exp_ese = e;
        exp_sre = m & 8'hbc;
        `CHK("ese", exp_ese, ese_q)
        `CHK("sre", exp_sre, sre_q)
    endtask

    task automatic push(input logic [15:0] c);
        @(posedge clk_in);
        err_code <= c;
        st_v[6] <= 1'b1;
        @(posedge clk_in);
        st_v[6] <= 1'b0;
        if (q.size() == DEPTH) q[q.size()-1] = 16'hfea2;
        else q.push_back(c);
    endtask

    task automatic pop();
        logic [15:0] e;
        pulse(5);
        e = (q.size() != 0) ? q.pop_front() : 16'h0000;
        `CHK("err", e, err_q)
    endtask

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_in);
        bad_count++;
        results();
    end

    initial begin
        seed = 32'h1599ff7e;
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        read_sev();
        read_sev();
        for (int i = 0; i < 5; i++) begin
            event_pulse(5'h01 << i);
            event_pulse(5'h01 << i);
            read_sev();
        end
        for (int n = 0; n < 24; n++) begin
            @(posedge clk_in);
            r = $random(seed);
            ques_ev <= r[15:0];
            ques_en <= r[31:16];
            r = $random(seed);
            oper_ev <= r[15:0];
            oper_en <= r[31:16];
            busy <= r[7];
            r = $random(seed);
            wr_masks(r[7:0], r[15:8]);
            event_pulse(r[20:16]);
            if (n % 3 == 0) push(r[31:16]);
            check_stb();
            if (n % 4 == 3) read_sev();
        end
        wr_masks(8'h00, 8'h00);
        model_en <= 1'b1;
        repeat (24) @(posedge clk_in);
        #1;
        `CHK("srq idle", 1'b0, srq)
        model_en <= 1'b0;
        busy <= 1'b0;
        wr_masks(8'h00, 8'h10);
        @(posedge clk_in);
        busy <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        `CHK("srq", 1'b1, srq)
        check_stb();
        `CHK("srq kept", 1'b1, srq)
        cnt0 = poll_cnt;
        r = $random(seed);
        @(posedge clk_in);
        model_dly <= r[3:0];
        model_en <= 1'b1;
        for (int k = 0; k < 40 && poll_cnt == cnt0; k++) @(posedge clk_in);
        #1;
        `CHK("poll", stb_f() | 8'h40, poll_byte)
        repeat (6) @(posedge clk_in);
        #1;
        `CHK("srq after poll", 1'b0, srq)
        `CHK("polls", cnt0 + 8'h01, poll_cnt)
        event_pulse(5'h04);
        pulse(1);
        q.delete();
        exp_sev = 8'h00;
        read_sev();
        for (int i = 0; i <= DEPTH; i++) begin
            r = $random(seed);
            push(r[15:0]);
        end
        check_stb();
        for (int i = 0; i <= DEPTH; i++) pop();
        check_stb();
        results();
    end
endmodule
`default_nettype wire
